// file: hdl/fwsp_cfg.svh
`ifndef FWSP_CFG_SVH
`define FWSP_CFG_SVH

// Clock period of hclk in nanoseconds.
`define FWSP_CLK_NS 100

// Strobe timing in nanoseconds: read access, write pulse width, recovery.
`define FWSP_T_RD_NS 90
`define FWSP_T_WP_NS 35
`define FWSP_T_REC_NS 30

// Least times round up to whole cycles, never fewer than one.
`define FWSP_CEIL(ns) (((ns) + `FWSP_CLK_NS - 1) / `FWSP_CLK_NS)
`define FWSP_RD_CYC (4'(`FWSP_CEIL(`FWSP_T_RD_NS)))
`define FWSP_WP_CYC (4'(`FWSP_CEIL(`FWSP_T_WP_NS)))
`define FWSP_REC_CYC (4'(`FWSP_CEIL(`FWSP_T_REC_NS)))
`define FWSP_CNT_ONE 4'h1
`define FWSP_CNT_ZERO 4'h0

// Register byte offsets on the AHB-Lite slave.
`define FWSP_OFS_CTRL 8'h00
`define FWSP_OFS_ADDR 8'h04
`define FWSP_OFS_WDATA 8'h08
`define FWSP_OFS_STATUS 8'h0c

// Control register fields.
`define FWSP_CTRL_START 0
`define FWSP_CTRL_ABORT 1
`define FWSP_CTRL_OP_LO 2
`define FWSP_CTRL_OP_HI 4

// Operation codes in the control register.
`define FWSP_OP_WRITE 3'h0
`define FWSP_OP_READ 3'h1
`define FWSP_OP_POLL 3'h2
`define FWSP_OP_GUARD 3'h3
`define FWSP_OP_PROT 3'h4

// Status byte bit positions on the flash data pins, and the address bit used for protection verify.
`define FWSP_BIT_DATA_ZERO 0
`define FWSP_BIT_TOGGLE_TWO 2
`define FWSP_BIT_ERASE_TIMER 3
`define FWSP_BIT_TIMEOUT 5
`define FWSP_BIT_TOGGLE_ONE 6
`define FWSP_ADDR_BIT_ONE 1

// Reset command byte written after a failed operation.
`define FWSP_RESET_CMD 8'hf0

// Read counter saturation and thresholds.
`define FWSP_RDCNT_MAX 3'h7
`define FWSP_RDCNT_ONE 3'h1
`define FWSP_RDCNT_PAIR 3'h2
`define FWSP_RDCNT_RECHECK 3'h4

`endif

// file: hdl/fwsp_pkg.sv
`default_nettype none

package fwsp_pkg;

  // Pins driven toward the flash device.
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fwsp_pins_t;

  // Orders from software to the sequencer.
  typedef struct packed {
    logic start;
    logic abort;
    logic [2:0] op;
    logic [18:0] addr;
    logic [7:0] wdata;
  } fwsp_cmd_t;

  // Status from the sequencer to software.
  typedef struct packed {
    logic busy;
    logic done;
    logic fail;
    logic prot;
    logic rejected;
    logic erasing;
    logic [7:0] data;
  } fwsp_stat_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR, ST_REC, ST_NEXT} fwsp_state_t;
  typedef enum logic [2:0] {STEP_A, STEP_B, STEP_C, STEP_D, STEP_E} fwsp_step_t;
  typedef enum logic [1:0] {ACT_RD, ACT_WR, ACT_END} fwsp_act_t;

endpackage : fwsp_pkg

`default_nettype wire

// file: hdl/fwsp_ahb_regs.sv
`include "fwsp_cfg.svh"
`default_nettype none

module fwsp_ahb_regs
  import fwsp_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Sequencer side.
  output fwsp_cmd_t cmd,
  input wire fwsp_stat_t stat
);

  logic wr_pend_reg;
  logic [7:0] wr_ofs_reg;

  // Address phase decode; only whole-word transfers are expected.
  wire take = hsel && hready && htrans[1];
  wire size_ok = (hsize == 3'h2);
  wire [7:0] ofs = haddr[7:0];
  wire [31:0] status_word = {16'h0000, stat.data, 2'h0, stat.erasing, stat.rejected,
                             stat.prot, stat.fail, stat.done, stat.busy};
  wire [31:0] ctrl_word = {27'h0000000, cmd.op, 2'h0};
  wire [31:0] rd_mux = (ofs == `FWSP_OFS_CTRL) ? ctrl_word :
                       (ofs == `FWSP_OFS_ADDR) ? {13'h0000, cmd.addr} :
                       (ofs == `FWSP_OFS_WDATA) ? {24'h000000, cmd.wdata} :
                       (ofs == `FWSP_OFS_STATUS) ? status_word : 32'h00000000;
  wire ctrl_hit = wr_pend_reg && (wr_ofs_reg == `FWSP_OFS_CTRL);

  // Address phase capture and read data; the slave never inserts waits.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= take && hwrite && size_ok;
      wr_ofs_reg <= ofs;
      if (take && !hwrite)
      begin
        hrdata <= rd_mux;
      end
    end
  end

  // Data phase writes; start and abort are one-cycle pulses.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd <= '0;
    end
    else
    begin
      cmd.start <= ctrl_hit && hwdata[`FWSP_CTRL_START];
      cmd.abort <= ctrl_hit && hwdata[`FWSP_CTRL_ABORT];
      if (ctrl_hit)
      begin
        cmd.op <= hwdata[`FWSP_CTRL_OP_HI:`FWSP_CTRL_OP_LO];
      end
      if (wr_pend_reg && (wr_ofs_reg == `FWSP_OFS_ADDR))
      begin
        cmd.addr <= hwdata[18:0];
      end
      if (wr_pend_reg && (wr_ofs_reg == `FWSP_OFS_WDATA))
      begin
        cmd.wdata <= hwdata[7:0];
      end
    end
  end

endmodule : fwsp_ahb_regs

`default_nettype wire

// file: hdl/fwsp_host.sv
// Overview of operation
// - Host reads the byte twice and compares; unchanged means finished.
// - Still toggling with timeout high: recheck, then reset on failure.
// - Host that leaves polling restarts the whole procedure from step one.
// - After a timeout whose recheck still toggles, the host writes reset before any new command.
// - Host checks erase timer flag before and after each added erase.
`include "fwsp_cfg.svh"
`default_nettype none

module fwsp_host
  import fwsp_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Flash device pins.
  output fwsp_pins_t flash_pins,
  input wire logic [7:0] flash_dq_in
);

  fwsp_cmd_t cmd;
  fwsp_stat_t stat;
  fwsp_state_t state_reg, state_next;
  fwsp_step_t step_reg, step_next;
  fwsp_act_t act;
  fwsp_step_t act_step;
  logic [7:0] act_byte;
  logic end_fail, end_prot, end_rej;
  fwsp_pins_t pins_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [2:0] op_reg;
  logic [18:0] addr_reg;
  logic [7:0] wdata_reg, last_reg, prev_reg;
  logic first_reg, done_reg, fail_reg, prot_reg, rej_reg, erasing_reg;
  logic [2:0] rd_cnt_reg;
  logic reset_sent_reg;

  // Register slave for software orders and status.
  fwsp_ahb_regs u_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .cmd(cmd),
    .stat(stat)
  );

  // Status word seen by software.
  assign stat = '{busy: (state_reg != ST_IDLE), done: done_reg, fail: fail_reg,
                  prot: prot_reg, rejected: rej_reg, erasing: erasing_reg, data: last_reg};

  // Decode of the last two status reads.
  wire tog_same = (prev_reg[`FWSP_BIT_TOGGLE_ONE] == last_reg[`FWSP_BIT_TOGGLE_ONE]);
  wire two_moved = (prev_reg[`FWSP_BIT_TOGGLE_TWO] != last_reg[`FWSP_BIT_TOGGLE_TWO]);
  wire timeout_hi = last_reg[`FWSP_BIT_TIMEOUT];
  wire timer_hi = last_reg[`FWSP_BIT_ERASE_TIMER];
  wire is_poll = (op_reg == `FWSP_OP_POLL);
  wire is_guard = (op_reg == `FWSP_OP_GUARD);
  wire at_next = (state_reg == ST_NEXT) && !first_reg;
  wire launch = (state_reg == ST_IDLE) && cmd.start;
  wire [18:0] rd_addr = (op_reg == `FWSP_OP_PROT) ?
                        (addr_reg | (19'h00001 << `FWSP_ADDR_BIT_ONE)) : addr_reg;

  // Decides the next flash access once the previous one has recovered.
  always_comb
  begin
    act = ACT_END;
    act_step = step_reg;
    act_byte = wdata_reg;
    end_fail = 1'b0;
    end_prot = 1'b0;
    end_rej = 1'b0;
    if (first_reg)
    begin
      act = (op_reg == `FWSP_OP_WRITE) ? ACT_WR : ACT_RD;
      act_step = STEP_A;
    end
    else if (is_poll)
    begin
      unique case (step_reg)
        STEP_A:
        begin
          act = ACT_RD;
          act_step = STEP_B;
        end
        STEP_B:
        begin
          if (!tog_same && timeout_hi)
          begin
            act = ACT_RD;
            act_step = STEP_C;
          end
          else if (!tog_same)
          begin
            act = ACT_RD;
            act_step = STEP_A;
          end
        end
        STEP_C:
        begin
          act = ACT_RD;
          act_step = STEP_D;
        end
        STEP_D:
        begin
          if (!tog_same)
          begin
            act = ACT_WR;
            act_step = STEP_E;
            act_byte = `FWSP_RESET_CMD;
          end
        end
        STEP_E:
        begin
          end_fail = 1'b1;
        end
      endcase
    end
    else if (is_guard)
    begin
      if (step_reg == STEP_A && !timer_hi)
      begin
        act = ACT_WR;
        act_step = STEP_B;
      end
      else if (step_reg == STEP_B)
      begin
        act = ACT_RD;
        act_step = STEP_C;
      end
      else
      begin
        end_rej = timer_hi;
      end
    end
    else if (op_reg == `FWSP_OP_PROT)
    begin
      end_prot = last_reg[`FWSP_BIT_DATA_ZERO];
    end
  end

  // Sequencer next state and strobe generation.
  always_comb
  begin
    state_next = state_reg;
    step_next = step_reg;
    cnt_next = cnt_reg;
    pins_next = flash_pins;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (cmd.start)
        begin
          state_next = ST_NEXT;
        end
      end
      ST_RD, ST_WR, ST_REC:
      begin
        if (cnt_reg != `FWSP_CNT_ZERO)
        begin
          cnt_next = cnt_reg - `FWSP_CNT_ONE;
        end
        else if (state_reg == ST_REC)
        begin
          state_next = ST_NEXT;
          pins_next.dq_oe = 1'b0;
        end
        else
        begin
          // Data stays driven one recovery period after the write strobe rises.
          state_next = ST_REC;
          cnt_next = `FWSP_REC_CYC - `FWSP_CNT_ONE;
          pins_next.ce_n = 1'b1;
          pins_next.oe_n = 1'b1;
          pins_next.we_n = 1'b1;
        end
      end
      ST_NEXT:
      begin
        if (cmd.abort || act == ACT_END)
        begin
          state_next = ST_IDLE;
        end
        else if (act == ACT_RD)
        begin
          state_next = ST_RD;
          step_next = act_step;
          cnt_next = `FWSP_RD_CYC - `FWSP_CNT_ONE;
          pins_next.addr = rd_addr;
          pins_next.ce_n = 1'b0;
          pins_next.oe_n = 1'b0;
        end
        else
        begin
          // A write strobe lasts whole cycles, far beyond any glitch width.
          state_next = ST_WR;
          step_next = act_step;
          cnt_next = `FWSP_WP_CYC - `FWSP_CNT_ONE;
          pins_next.addr = addr_reg;
          pins_next.dq_out = act_byte;
          pins_next.dq_oe = 1'b1;
          pins_next.oe_n = 1'b1;
          pins_next.ce_n = 1'b0;
          pins_next.we_n = 1'b0;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer and pin registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_IDLE;
      step_reg <= STEP_A;
      cnt_reg <= `FWSP_CNT_ZERO;
      flash_pins <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end
    else
    begin
      state_reg <= state_next;
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      flash_pins <= pins_next;
    end
  end

  // Order capture; a start while busy is ignored.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_reg <= `FWSP_OP_WRITE;
      addr_reg <= '0;
      wdata_reg <= 8'h00;
      first_reg <= 1'b0;
    end
    else
    begin
      if (launch)
      begin
        op_reg <= cmd.op;
        addr_reg <= cmd.addr;
        wdata_reg <= cmd.wdata;
      end
      first_reg <= launch;
    end
  end

  // Read capture at the end of the access time.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_reg <= 8'h00;
      prev_reg <= 8'h00;
      rd_cnt_reg <= 3'h0;
    end
    else if (launch)
    begin
      rd_cnt_reg <= 3'h0;
    end
    else if (state_reg == ST_RD && cnt_reg == `FWSP_CNT_ZERO)
    begin
      prev_reg <= last_reg;
      last_reg <= flash_dq_in;
      if (rd_cnt_reg != `FWSP_RDCNT_MAX)
      begin
        rd_cnt_reg <= rd_cnt_reg + `FWSP_RDCNT_ONE;
      end
    end
  end

  // Result flags; a new start clears all but erasing, completion sets done, fail, prot and rejected.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      prot_reg <= 1'b0;
      rej_reg <= 1'b0;
      erasing_reg <= 1'b0;
      reset_sent_reg <= 1'b0;
    end
    else if (launch)
    begin
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      prot_reg <= 1'b0;
      rej_reg <= 1'b0;
      reset_sent_reg <= 1'b0;
    end
    else if (at_next)
    begin
      if (act == ACT_END && !cmd.abort)
      begin
        done_reg <= 1'b1;
        fail_reg <= end_fail;
        prot_reg <= end_prot;
        rej_reg <= end_rej;
      end
      if (is_poll && step_reg == STEP_B)
      begin
        erasing_reg <= two_moved;
      end
      if (act == ACT_WR && act_step == STEP_E)
      begin
        reset_sent_reg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_write_strobe_inhibit: assert property (!flash_pins.we_n |-> flash_pins.oe_n &&
    !flash_pins.ce_n && flash_pins.dq_oe) else $error("write strobe without inhibit release");

  a_poll_two_reads: assert property (at_next && is_poll && act == ACT_END && !end_fail
    |-> rd_cnt_reg >= `FWSP_RDCNT_PAIR) else $error("poll ended before two reads");

  a_fail_after_recheck: assert property ($rose(fail_reg) |->
    rd_cnt_reg >= `FWSP_RDCNT_RECHECK && reset_sent_reg) else $error("fail without recheck");

  a_reset_after_timeout: assert property (at_next && is_poll && step_reg == STEP_D &&
    !tog_same && !cmd.abort |=> !flash_pins.we_n && flash_pins.dq_out == `FWSP_RESET_CMD)
    else $error("reset command not written after failed recheck");

  a_restart_first_step: assert property (at_next && is_poll && step_reg == STEP_B &&
    !tog_same && !timeout_hi && !cmd.abort |=> state_reg == ST_RD && step_reg == STEP_A)
    else $error("poll did not restart from first read");

  a_guard_refuse_write: assert property (at_next && is_guard && step_reg == STEP_A &&
    timer_hi |=> state_reg == ST_IDLE ##1 flash_pins.we_n && rej_reg)
    else $error("guarded write not refused");

  a_guard_post_check: assert property (at_next && is_guard && step_reg == STEP_B &&
    !cmd.abort |=> !flash_pins.oe_n ##[1:20] (state_reg == ST_IDLE && done_reg))
    else $error("guarded write not rechecked");

endmodule : fwsp_host

`default_nettype wire

// file: dv/fwsp_flash_model.sv
`default_nettype none

module fwsp_flash_model
  import fwsp_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h3c // Arbitrary identification value.
)
(
  // Clock and pins from the host.
  input wire logic hclk,
  input wire fwsp_pins_t pins,
  output logic [7:0] dq,
  // Scenario knobs from the bench.
  input wire logic arm,
  input wire logic [7:0] run_reads,
  input wire logic stuck,
  input wire logic tmr,
  input wire logic id_mode,
  input wire logic [7:0] erase_sel,
  input wire logic [7:0] prot_map,
  // Writes seen on the pins.
  output logic [15:0] wr_cnt,
  output logic [18:0] wr_addr,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left, last, stat, arr, data;
  logic stk, t1, t2;
  wire logic busy = (left != 8'h00) || stk;
  wire logic rd = !pins.ce_n && !pins.oe_n;
  wire logic [2:0] sec = pins.addr[18:16];

  // The device comes up idle in array read mode.
  initial
  begin
    {left, last, stk, t1, t2, wr_cnt, wr_addr, wr_data} = '0;
  end

  // Status byte while an algorithm runs, a fixed pattern as array data otherwise.
  assign stat = {1'b0, t1, stk, 1'b0, tmr, t2, 2'b00};
  assign arr = pins.addr[7:0] ^ {5'h00, sec} ^ 8'ha5;
  assign data = id_mode ? (pins.addr[1] ? {7'h00, prot_map[sec]} : ID_CODE)
    : (busy ? stat : arr);
  // A released bus shows the inverse of the last byte, never a stale copy.
  assign dq = rd ? data : ~last;

  // Reads while busy flip toggle bit one, and toggle bit two where erase_sel marks the sector; a write needs both strobes low with output enable high.
  always @(posedge hclk)
  begin
    if (rd)
    begin
      last <= data;
      if (busy)
      begin
        t1 <= ~t1;
        if (erase_sel[sec])
          t2 <= ~t2;
        if (left != 8'h00)
          left <= left - 8'h01;
      end
    end
    // A strobe seen low at a clock edge lasts a whole cycle, far past the glitch limit.
    if (!pins.ce_n && !pins.we_n && pins.oe_n && !tmr)
    begin
      wr_cnt <= wr_cnt + 16'h0001;
      wr_addr <= pins.addr;
      wr_data <= pins.dq_out;
      if (pins.dq_out == 8'hf0)
        {left, stk} <= '0;
    end
    if (arm)
    begin
      left <= run_reads;
      stk <= stuck;
    end
  end

endmodule : fwsp_flash_model

`default_nettype wire

// file: dv/fwsp_host_tb.sv
`default_nettype none

module fwsp_host_tb
  import fwsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary identification value.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, arm, stuck, tmr, id_mode;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, st, a, d;
  logic [7:0] dq, run_reads, erase_sel, prot_map, wr_data;
  logic [15:0] wr_cnt, cnt;
  logic [18:0] wr_addr;
  fwsp_pins_t pins;
  int miscompares, num_checks, cyc, seed, i;

  // Bench clock at 10 MHz.
  always #50 hclk = ~hclk;

  fwsp_host uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flash_pins(pins),
    .flash_dq_in(dq));

  fwsp_flash_model #(.ID_CODE(ID_VAL)) dev (.hclk(hclk), .pins(pins), .dq(dq), .arm(arm),
    .run_reads(run_reads), .stuck(stuck), .tmr(tmr), .id_mode(id_mode),
    .erase_sel(erase_sel), .prot_map(prot_map), .wr_cnt(wr_cnt), .wr_addr(wr_addr),
    .wr_data(wr_data));

  // Compares one value and reports a mismatch at once.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task close_out;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // One single AHB-Lite transfer; read data is taken at the end of the data phase.
  task ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  // Starts an order and waits for done; the first status read may predate the start.
  task run(input logic [2:0] op, output logic [31:0] s);
    int n;
    ahb(1'b1, 8'h00, {27'h0, op, 2'b01}, s);
    ahb(1'b0, 8'h0c, 32'h0, s);
    n = 0;
    do
    begin
      ahb(1'b0, 8'h0c, 32'h0, s);
      n++;
    end
    while (s[1] !== 1'b1 && n < 200);
    chk(32'(s[1:0]), 32'h2);
  endtask : run

  // Array pattern expected at an idle device.
  function automatic logic [7:0] exp_arr(input logic [18:0] ad);
    return ad[7:0] ^ {5'h00, ad[18:16]} ^ 8'ha5;
  endfunction : exp_arr

  // Cuts a hang short.
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc >= 40000)
    begin
      miscompares++;
      close_out;
    end
  end

  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, arm, stuck, tmr, id_mode} = '0;
    {run_reads, erase_sel, prot_map} = '0;
    seed = 33124;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset status value and an unmapped place.
    ahb(1'b0, 8'h0c, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, 8'h10, 32'hffffffff, rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    // Byte writes land on the pins with address and data intact.
    for (i = 0; i < 4; i++)
    begin
      a = $random(seed);
      d = $random(seed);
      ahb(1'b1, 8'h04, a, rd);
      ahb(1'b1, 8'h08, d, rd);
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk(rd, a & 32'h7ffff);
      ahb(1'b0, 8'h08, 32'h0, rd);
      chk(rd, d & 32'hff);
      run(3'h0, st);
      chk(32'(st[2]), 32'h0);
      chk(32'(wr_addr), a & 32'h7ffff);
      chk(32'(wr_data), d & 32'hff);
      run(3'h1, st);
      chk(32'(st[15:8]), 32'(exp_arr(a[18:0])));
    end
    // Toggle polls: finishing runs pass, a stuck run fails and is reset.
    for (i = 0; i < 8; i++)
    begin
      a = $random(seed);
      ahb(1'b1, 8'h04, a, rd);
      // Even busy-read counts keep a status read from pairing with an array read.
      run_reads <= 8'(2 * ($unsigned($random(seed)) % 4));
      erase_sel <= 8'($random(seed));
      stuck <= (i >= 5);
      arm <= 1'b1;
      @(posedge hclk);
      arm <= 1'b0;
      run(3'h2, st);
      chk(32'(st[2]), 32'(stuck));
      chk(32'(st[5]), 32'(stuck & erase_sel[a[18:16]]));
      if (stuck)
        chk(32'(wr_data), 32'hf0);
      run(3'h1, st);
      chk(32'(st[15:8]), 32'(exp_arr(a[18:0])));
    end
    // Guarded erase-add write with the erase timer high and low.
    for (i = 0; i < 2; i++)
    begin
      // Keep the device busy so its reads carry the erase timer bit.
      tmr <= (i == 0);
      run_reads <= 8'h04;
      arm <= 1'b1;
      @(posedge hclk);
      arm <= 1'b0;
      cnt = wr_cnt;
      run(3'h3, st);
      chk(32'(st[4]), 32'(i == 0));
      chk(32'(wr_cnt), 32'(cnt) + 32'(i));
    end
    tmr <= 1'b0;
    // Protection verify per sector, then an identification read.
    id_mode <= 1'b1;
    prot_map <= 8'($random(seed));
    for (i = 0; i < 8; i++)
    begin
      a = {13'h0, 3'(i), 16'($random(seed))};
      ahb(1'b1, 8'h04, a, rd);
      run(3'h4, st);
      chk(32'(st[3]), 32'(prot_map[i]));
      chk(32'(st[15:8]), 32'(prot_map[i]));
    end
    ahb(1'b1, 8'h04, 32'h0, rd);
    run(3'h1, st);
    chk(32'(st[15:8]), 32'(ID_VAL));
    close_out;
  end

endmodule : fwsp_host_tb

`default_nettype wire
